// >>> inc/omm_pkg.sv
// Package for the optical module management and status block.
// Assumes a single 100 MHz mclk domain; the host's two-wire pins are sampled in it.
// Overview of operation
// - Identification memory, 256 bytes, answers at two-wire address 0xA0 for reads.
// - Diagnostics memory, 256 bytes, answers at two-wire address 0xA2.
// - Diagnostics memory carries live supply, temperature, bias, power and receive power.
// - Transmit-off input high shuts the transmitter; low lets it run.
// - Undriven transmit-off input is treated as high, so transmitter starts disabled.
// - Toggling transmit-off high then low clears a latched fault.
// - Software transmit-off is bit 6 of diagnostics byte 110, host writable.
// - Bit 7 of byte 110 reads back the transmit-off input state.
// - Transmitter disable is software bit OR hardware input.
// - Laser fault disables the laser and drives the fault output high.
// - Fault stays latched until transmit-off toggles or power cycles.
// - Bit 2 of byte 110 reads the transmitter fault.
// - Receive-loss output is high without modulation, low with valid modulation.
// - Bit 1 of byte 110 mirrors receive-loss status.
package omm_pkg;
    localparam logic [6:0] ID_DEV_ADDR = 7'h50;   // 0xA0 as eight-bit address
    localparam logic [6:0] DIAG_DEV_ADDR = 7'h51; // 0xA2 as eight-bit address
    localparam logic [7:0] TX_STATUS_CONTROL = 8'h6e;
    localparam int BIT_TX_OFF_STATE = 7;
    localparam int BIT_SOFT_TX_OFF = 6;
    localparam int BIT_TX_FAULT = 2;
    localparam int BIT_RX_LOST = 1;
    // Diagnostic monitor byte offsets, big-endian 16-bit words
    localparam logic [7:0] MON_TEMP = 8'h60;
    localparam logic [7:0] MON_VCC = 8'h62;
    localparam logic [7:0] MON_BIAS = 8'h64;
    localparam logic [7:0] MON_TXPWR = 8'h66;
    localparam logic [7:0] MON_RXPWR = 8'h68;
    localparam logic [7:0] SOFT_RESET_VAL = 8'h00;

    typedef struct packed {
        logic [15:0] temperature;
        logic [15:0] supply;
        logic [15:0] bias;
        logic [15:0] txPower;
        logic [15:0] rxPower;
    } omm_monitor_t;

    typedef enum logic [2:0] {
        OMM_IDLE, OMM_ADDR, OMM_ACK, OMM_WDATA, OMM_RDATA, OMM_RACK
    } omm_state_t;
endpackage

// >>> hdl/omm_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous pin; the output changes once stages two and three agree.
`timescale 1ns/1ns
module omm_pin_sync
    import omm_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pinIn,
    output logic pinOut
);
    logic [2:0] stage_ff;
    logic out_ff;
    logic [2:0] nxt_stage;
    logic nxt_out;

    // Stage one feeds only stage two; filter looks at two and three
    always_comb begin
        nxt_stage = {stage_ff[1:0], pinIn};
        nxt_out = out_ff;
        if (stage_ff[1] == stage_ff[2]) begin
            nxt_out = stage_ff[2];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            stage_ff <= {3{RESET_LEVEL}};
            out_ff <= RESET_LEVEL;
        end else begin
            stage_ff <= nxt_stage;
            out_ff <= nxt_out;
        end
    end

    assign pinOut = out_ff;
endmodule

// >>> hdl/omm_mgmt_status.sv
// Management and status logic of a pluggable optical module.
// Assumes host two-wire pins sampled in mclk; identification contents loaded via idWrite port.
`timescale 1ns/1ns
module omm_mgmt_status
    import omm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic txOffPin,
    input wire logic txOffPinDriven,
    input wire logic laserFaultEvent,
    input wire logic signalPresent,
    input wire omm_monitor_t monitors,
    input wire logic idWrite,
    input wire logic [7:0] idWrAddr,
    input wire logic [7:0] idWrData,
    output logic txFault,
    output logic receive_signal_lost,
    output logic laserEnable
);
    logic sclS, sdaS, txOffS, rxPresS;
    logic [7:0] idMem [256];
    logic [7:0] diagMem [256];

    // Undriven input reads as pulled up
    logic txOffLevel;
    assign txOffLevel = txOffPin | ~txOffPinDriven;

    omm_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_tx (.mclk(mclk), .rst(rst), .pinIn(txOffLevel), .pinOut(txOffS));
    omm_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_scl (.mclk(mclk), .rst(rst), .pinIn(sclIn), .pinOut(sclS));
    omm_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_sda (.mclk(mclk), .rst(rst), .pinIn(sdaIn), .pinOut(sdaS));
    omm_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_rx (.mclk(mclk), .rst(rst), .pinIn(signalPresent),
        .pinOut(rxPresS));

    // Status and control group
    logic softOff_ff, nxt_softOff;
    logic fault_ff, nxt_fault;
    logic txOffPrev_ff, nxt_txOffPrev;
    logic armed_ff, nxt_armed;
    logic los_ff, nxt_los;
    logic laser_ff, nxt_laser;

    // Bus group
    omm_state_t state_ff, nxt_state;
    logic sclPrev_ff, nxt_sclPrev, sdaPrev_ff, nxt_sdaPrev;
    logic [7:0] shift_ff, nxt_shift;
    logic [3:0] bitCnt_ff, nxt_bitCnt;
    logic [7:0] ptr_ff, nxt_ptr;
    logic diagSel_ff, nxt_diagSel;
    logic isRead_ff, nxt_isRead;
    logic havePtr_ff, nxt_havePtr;
    logic sdaOe_ff, nxt_sdaOe;
    logic wrStrobe;
    logic [7:0] wrData;

    wire sclRise = sclS & ~sclPrev_ff;
    wire sclFall = ~sclS & sclPrev_ff;
    wire startCond = sclS & sdaPrev_ff & ~sdaS;
    wire stopCond = sclS & ~sdaPrev_ff & sdaS;

    // Live status byte; only bit 6 is stored
    function automatic logic [7:0] statusByte();
        logic [7:0] b;
        b = 8'h00;
        b[BIT_TX_OFF_STATE] = txOffS;
        b[BIT_SOFT_TX_OFF] = softOff_ff;
        b[BIT_TX_FAULT] = fault_ff;
        b[BIT_RX_LOST] = los_ff;
        return b;
    endfunction

    // Read byte mux; monitor words are live so reads never see stale values
    function automatic logic [7:0] readByte(input logic diag, input logic [7:0] a);
        logic [7:0] b;
        b = idMem[a];
        if (diag) begin
            unique case (a)
                MON_TEMP: b = monitors.temperature[15:8];
                MON_TEMP + 8'h01: b = monitors.temperature[7:0];
                MON_VCC: b = monitors.supply[15:8];
                MON_VCC + 8'h01: b = monitors.supply[7:0];
                MON_BIAS: b = monitors.bias[15:8];
                MON_BIAS + 8'h01: b = monitors.bias[7:0];
                MON_TXPWR: b = monitors.txPower[15:8];
                MON_TXPWR + 8'h01: b = monitors.txPower[7:0];
                MON_RXPWR: b = monitors.rxPower[15:8];
                MON_RXPWR + 8'h01: b = monitors.rxPower[7:0];
                TX_STATUS_CONTROL: b = statusByte();
                default: b = diagMem[a];
            endcase
        end
        return b;
    endfunction

    // Transmit control, fault latch and receive loss
    always_comb begin
        nxt_softOff = softOff_ff;
        if (wrStrobe && diagSel_ff && ptr_ff == TX_STATUS_CONTROL) begin
            nxt_softOff = wrData[BIT_SOFT_TX_OFF];
        end
        nxt_txOffPrev = txOffS;
        nxt_armed = armed_ff;
        nxt_fault = fault_ff;
        if (fault_ff && txOffS) begin
            nxt_armed = 1'b1; // High half of the clearing toggle
        end
        if (armed_ff && txOffPrev_ff && !txOffS) begin
            nxt_fault = 1'b0; // Falling edge completes toggle
            nxt_armed = 1'b0;
        end
        if (laserFaultEvent) begin
            nxt_fault = 1'b1; // New fault wins over a clear
            nxt_armed = 1'b0;
        end
        nxt_los = ~rxPresS;
        // Either control stops light; a fault also does
        nxt_laser = ~(txOffS | nxt_softOff | nxt_fault);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            softOff_ff <= 1'b0;
            fault_ff <= 1'b0;
            txOffPrev_ff <= 1'b1;
            armed_ff <= 1'b0;
            los_ff <= 1'b1;
            laser_ff <= 1'b0; // Starts dark until pin is seen low
        end else begin
            softOff_ff <= nxt_softOff;
            fault_ff <= nxt_fault;
            txOffPrev_ff <= nxt_txOffPrev;
            armed_ff <= nxt_armed;
            los_ff <= nxt_los;
            laser_ff <= nxt_laser;
        end
    end

    // Two-wire slave: pointer write then data writes, or sequential reads
    always_comb begin
        nxt_state = state_ff;
        nxt_sclPrev = sclS;
        nxt_sdaPrev = sdaS;
        nxt_shift = shift_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_ptr = ptr_ff;
        nxt_diagSel = diagSel_ff;
        nxt_isRead = isRead_ff;
        nxt_havePtr = havePtr_ff;
        nxt_sdaOe = sdaOe_ff;
        wrStrobe = 1'b0;
        wrData = shift_ff;
        if (startCond) begin
            nxt_state = OMM_ADDR;
            nxt_bitCnt = 4'h0;
            nxt_sdaOe = 1'b0;
        end else if (stopCond) begin
            nxt_state = OMM_IDLE;
            nxt_sdaOe = 1'b0;
        end else begin
            unique case (state_ff)
                OMM_IDLE: nxt_sdaOe = 1'b0;
                OMM_ADDR, OMM_WDATA: begin
                    if (sclRise) begin
                        nxt_shift = {shift_ff[6:0], sdaS};
                        nxt_bitCnt = bitCnt_ff + 4'h1;
                    end
                    if (sclFall && bitCnt_ff == 4'h8) begin
                        nxt_bitCnt = 4'h0;
                        if (state_ff == OMM_ADDR) begin
                            if (shift_ff[7:1] == ID_DEV_ADDR || shift_ff[7:1] == DIAG_DEV_ADDR) begin
                                nxt_diagSel = (shift_ff[7:1] == DIAG_DEV_ADDR);
                                nxt_isRead = shift_ff[0];
                                nxt_havePtr = 1'b0;
                                nxt_sdaOe = 1'b1; // Acknowledge
                                nxt_state = OMM_ACK;
                            end else begin
                                nxt_state = OMM_IDLE; // Not ours
                            end
                        end else begin
                            nxt_sdaOe = 1'b1;
                            nxt_state = OMM_ACK;
                            if (!havePtr_ff) begin
                                nxt_ptr = shift_ff;
                                nxt_havePtr = 1'b1;
                            end else begin
                                wrStrobe = 1'b1;
                                nxt_ptr = ptr_ff + 8'h01;
                            end
                        end
                    end
                end
                OMM_ACK: begin
                    if (sclFall) begin
                        if (isRead_ff) begin
                            nxt_shift = readByte(diagSel_ff, ptr_ff);
                            nxt_sdaOe = ~nxt_shift[7];
                            nxt_bitCnt = 4'h1;
                            nxt_state = OMM_RDATA;
                        end else begin
                            nxt_sdaOe = 1'b0;
                            nxt_state = OMM_WDATA;
                        end
                    end
                end
                OMM_RDATA: begin
                    if (sclFall) begin
                        if (bitCnt_ff == 4'h8) begin
                            nxt_sdaOe = 1'b0; // Release for host acknowledge
                            nxt_ptr = ptr_ff + 8'h01;
                            nxt_state = OMM_RACK;
                        end else begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_sdaOe = ~shift_ff[6];
                            nxt_bitCnt = bitCnt_ff + 4'h1;
                        end
                    end
                end
                OMM_RACK: begin
                    if (sclRise) begin
                        nxt_state = sdaS ? OMM_IDLE : OMM_ACK; // High means host is done
                    end
                end
                default: nxt_state = OMM_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= OMM_IDLE;
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
            shift_ff <= SOFT_RESET_VAL;
            bitCnt_ff <= 4'h0;
            ptr_ff <= SOFT_RESET_VAL;
            diagSel_ff <= 1'b0;
            isRead_ff <= 1'b0;
            havePtr_ff <= 1'b0;
            sdaOe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sclPrev_ff <= nxt_sclPrev;
            sdaPrev_ff <= nxt_sdaPrev;
            shift_ff <= nxt_shift;
            bitCnt_ff <= nxt_bitCnt;
            ptr_ff <= nxt_ptr;
            diagSel_ff <= nxt_diagSel;
            isRead_ff <= nxt_isRead;
            havePtr_ff <= nxt_havePtr;
            sdaOe_ff <= nxt_sdaOe;
        end
    end

    // Memory arrays; identification is read-only to the host
    always_ff @(posedge mclk) begin
        if (idWrite) begin
            idMem[idWrAddr] <= idWrData;
        end
        if (wrStrobe && diagSel_ff) begin
            diagMem[ptr_ff] <= wrData;
        end
    end

    assign sdaOut = 1'b0; // Open drain: only ever pulls low
    assign sdaOe = sdaOe_ff;
    assign txFault = fault_ff;
    assign receive_signal_lost = los_ff;
    assign laserEnable = laser_ff;
endmodule

// >>> dv/omm_mgmt_status_monitor.sv
// Checker for the management block: fault latch, transmit-off, receive-loss and bus timing.
// Assumes it is bound to omm_mgmt_status and sees only its ports.
`timescale 1ns/1ns
module omm_mgmt_status_monitor
    import omm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaOe,
    input wire logic txOffPin,
    input wire logic txOffPinDriven,
    input wire logic laserFaultEvent,
    input wire logic signalPresent,
    input wire logic txFault,
    input wire logic receive_signal_lost,
    input wire logic laserEnable
);
    logic [3:0] lowCnt_ff;
    logic [3:0] nxt_lowCnt;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Clocks the transmit-off pin has been driven low; past eight no clear can still be pending
    always_comb begin
        nxt_lowCnt = lowCnt_ff;
        if (rst || txOffPin || !txOffPinDriven)
            nxt_lowCnt = 4'h0;
        else if (lowCnt_ff != 4'hf)
            nxt_lowCnt = lowCnt_ff + 4'h1;
    end
    // Register only
    always_ff @(posedge mclk) begin
        lowCnt_ff <= nxt_lowCnt;
    end
    property p_fault_set; laserFaultEvent |=> txFault; endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault event not latched");
    property p_fault_dark; txFault |-> !laserEnable; endproperty
    a_fault_dark: assert property (p_fault_dark) else $error("laser on during fault");
    property p_fault_rise; $rose(txFault) |-> $past(laserFaultEvent); endproperty
    a_fault_rise: assert property (p_fault_rise) else $error("fault set without event");
    property p_fault_hold; txFault && lowCnt_ff > 4'h7 |=> txFault; endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault cleared without toggle");
    property p_hw_off; (txOffPin || !txOffPinDriven) [*8] |-> !laserEnable; endproperty
    a_hw_off: assert property (p_hw_off) else $error("laser on while pin off");
    property p_los_hi; !signalPresent [*8] |-> receive_signal_lost; endproperty
    a_los_hi: assert property (p_los_hi) else $error("loss flag low without signal");
    property p_los_lo; signalPresent [*8] |-> !receive_signal_lost; endproperty
    a_los_lo: assert property (p_los_lo) else $error("loss flag high with signal");
    property p_sda_edge; $changed(sdaOe) |-> !sclIn; endproperty
    a_sda_edge: assert property (p_sda_edge) else $error("data changed while clock high");
endmodule

// >>> dv/omm_host_model.sv
// Host management controller model: drives the two-wire clock and open-drain data.
// Assumes the bench resolves the data wire with a pull-up and feeds it back here.
`timescale 1ns/1ns
module omm_host_model
    import omm_pkg::*;
(
    input wire logic mclk,
    input wire logic sdaWire,
    output logic scl,
    output logic sdaRel
);
    // Bus idles with both lines high; the clock stands still between frames
    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end
    // Each step lasts six clocks, so a clock half-period is twelve, above the eight needed
    task automatic drv(input logic c, input logic d);
        @(posedge mclk);
        scl <= c;
        sdaRel <= d;
        repeat (5) @(posedge mclk);
    endtask
    // Data moves only after the clock has fallen, so no false start or stop appears
    task automatic bitIo(input logic d, output logic q);
        drv(1'b0, sdaRel);
        drv(1'b0, d);
        drv(1'b1, d);
        drv(1'b1, d);
        q = sdaWire;
    endtask
    task automatic startC();
        drv(1'b0, sdaRel);
        drv(1'b0, 1'b1);
        drv(1'b1, 1'b1);
        drv(1'b1, 1'b0);
    endtask
    task automatic stopC();
        drv(1'b0, sdaRel);
        drv(1'b0, 1'b0);
        drv(1'b1, 1'b0);
        drv(1'b1, 1'b1);
    endtask
    // Eight bits out and in, then the acknowledge slot; mAck low releases the line
    task automatic byteIo(input logic [7:0] tx, input logic mAck, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            bitIo(tx[i], rx[i]);
        bitIo(!mAck, ack);
        ack = !ack;
    endtask
endmodule

// >>> dv/test_optical_module_mgmt_status.sv
// Self-checking bench for the management block through host two-wire transfers and pins.
// Assumes omm_host_model as the host and the bound monitor watching the ports.
`timescale 1ns/1ns
module test_optical_module_mgmt_status
    import omm_pkg::*;
;
    logic mclk;
    logic rst, txOffPin, txOffPinDriven, laserFaultEvent, signalPresent, idWrite, ackBit;
    logic sclIn, sdaRel, sdaOut, sdaOe, txFault, receive_signal_lost, laserEnable;
    logic [7:0] idWrAddr, idWrData, rd;
    omm_monitor_t monitors;
    wire logic sdaWire;
    int errCount, nChecks;
    // Open-drain data wire with pull-up
    // The module's driven level only counts while its enable is high, so a wrong sdaOut breaks acknowledges
    assign sdaWire = sdaRel & (~sdaOe | sdaOut);
    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    omm_mgmt_status u_dut (.mclk(mclk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .txOffPin(txOffPin), .txOffPinDriven(txOffPinDriven), .laserFaultEvent(laserFaultEvent),
        .signalPresent(signalPresent), .monitors(monitors), .idWrite(idWrite), .idWrAddr(idWrAddr),
        .idWrData(idWrData), .txFault(txFault), .receive_signal_lost(receive_signal_lost),
        .laserEnable(laserEnable));
    omm_host_model u_host (.mclk(mclk), .sdaWire(sdaWire), .scl(sclIn), .sdaRel(sdaRel));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stopTest();
        if (errCount == 0 && nChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Pin synchronisers take about four clocks, so eight leaves margin
    task automatic settle();
        repeat (8) @(posedge mclk);
    endtask
    task automatic setPtr(input logic [6:0] dev, input logic [7:0] ptr);
        logic [7:0] r;
        logic a;
        u_host.startC();
        u_host.byteIo({dev, 1'b0}, 1'b0, r, a);
        check(8'(a), 8'h01);
        u_host.byteIo(ptr, 1'b0, r, a);
        check(8'(a), 8'h01);
    endtask
    task automatic wrReg(input logic [7:0] ptr, input logic [7:0] d);
        logic [7:0] r;
        logic a;
        setPtr(DIAG_DEV_ADDR, ptr);
        u_host.byteIo(d, 1'b0, r, a);
        check(8'(a), 8'h01);
        u_host.stopC();
    endtask
    // Repeated start turns the pointer write into a one-byte read ended by no-acknowledge
    task automatic rdReg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] d;
        logic a;
        setPtr(dev, ptr);
        u_host.startC();
        u_host.byteIo({dev, 1'b1}, 1'b0, d, a);
        check(8'(a), 8'h01);
        u_host.byteIo(8'hff, 1'b0, d, a);
        u_host.stopC();
        check(d, exp);
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        txOffPin = 1'b1;
        txOffPinDriven = 1'b0;
        laserFaultEvent = 1'b0;
        signalPresent = 1'b0;
        idWrite = 1'b0;
        idWrAddr = 8'h00;
        idWrData = 8'h00;
        monitors = 80'h1234_5678_9abc_def0_0f1e;
        errCount = 0;
        nChecks = 0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        signalPresent <= 1'b1;
        settle();
        check(8'(laserEnable), 8'h00);
        check(8'(receive_signal_lost), 8'h00);
        txOffPinDriven <= 1'b1;
        settle();
        check(8'(laserEnable), 8'h00);
        txOffPin <= 1'b0;
        settle();
        check(8'(laserEnable), 8'h01);
        // Load the first and last identification bytes
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            idWrite <= 1'b1;
            idWrAddr <= 8'(i * 255);
            idWrData <= 8'hc3 ^ 8'(i);
        end
        @(posedge mclk);
        idWrite <= 1'b0;
        rdReg(ID_DEV_ADDR, 8'h00, 8'hc3);
        rdReg(ID_DEV_ADDR, 8'hff, 8'hc2);
        // Host writes to the identification memory must not land
        setPtr(ID_DEV_ADDR, 8'h00);
        u_host.byteIo(8'h00, 1'b0, rd, ackBit);
        u_host.stopC();
        rdReg(ID_DEV_ADDR, 8'h00, 8'hc3);
        for (int i = 0; i < 10; i++)
            rdReg(DIAG_DEV_ADDR, MON_TEMP + 8'(i), monitors[79 - 8 * i -: 8]);
        rdReg(DIAG_DEV_ADDR, TX_STATUS_CONTROL, 8'h00);
        wrReg(TX_STATUS_CONTROL, 8'hff);
        check(8'(laserEnable), 8'h00);
        rdReg(DIAG_DEV_ADDR, TX_STATUS_CONTROL, 8'h40);
        txOffPin <= 1'b1;
        settle();
        rdReg(DIAG_DEV_ADDR, TX_STATUS_CONTROL, 8'hc0);
        txOffPin <= 1'b0;
        wrReg(TX_STATUS_CONTROL, 8'h00);
        check(8'(laserEnable), 8'h01);
        signalPresent <= 1'b0;
        settle();
        check(8'(receive_signal_lost), 8'h01);
        rdReg(DIAG_DEV_ADDR, TX_STATUS_CONTROL, 8'h02);
        signalPresent <= 1'b1;
        // Fault, then clear by toggling the pin, then a second fault cleared by reset
        for (int k = 0; k < 2; k++) begin
            laserFaultEvent <= 1'b1;
            @(posedge mclk);
            laserFaultEvent <= 1'b0;
            settle();
            check(8'({txFault, laserEnable}), 8'h02);
            rdReg(DIAG_DEV_ADDR, TX_STATUS_CONTROL, 8'h04);
            txOffPin <= 1'(k == 0);
            settle();
            rst <= 1'(k == 1);
            txOffPin <= 1'b0;
            settle();
            rst <= 1'b0;
            settle();
            check(8'({txFault, laserEnable}), 8'h01);
        end
        // Two-byte write and acknowledged sequential read cover pointer increment and host acknowledge
        setPtr(DIAG_DEV_ADDR, 8'h80);
        for (int j = 0; j < 2; j++) begin
            u_host.byteIo(8'h5a ^ 8'(j * 255), 1'b0, rd, ackBit);
            check(8'(ackBit), 8'h01);
        end
        u_host.stopC();
        setPtr(DIAG_DEV_ADDR, 8'h80);
        u_host.startC();
        u_host.byteIo({DIAG_DEV_ADDR, 1'b1}, 1'b0, rd, ackBit);
        check(8'(ackBit), 8'h01);
        for (int j = 0; j < 2; j++) begin
            u_host.byteIo(8'hff, 1'(j == 0), rd, ackBit);
            check(rd, 8'h5a ^ 8'(j * 255));
        end
        u_host.stopC();
        u_host.startC();
        u_host.byteIo({7'h52, 1'b0}, 1'b0, rd, ackBit);
        check(8'(ackBit), 8'h00);
        u_host.stopC();
        stopTest();
    end
endmodule
bind omm_mgmt_status omm_mgmt_status_monitor u_mon (.mclk(mclk), .rst(rst), .sclIn(sclIn), .sdaOe(sdaOe),
    .txOffPin(txOffPin), .txOffPinDriven(txOffPinDriven), .laserFaultEvent(laserFaultEvent),
    .signalPresent(signalPresent), .txFault(txFault), .receive_signal_lost(receive_signal_lost),
    .laserEnable(laserEnable));
